// [core/config_word_osc_reset_select.v]
// configuration word decode, reset hold, watchdog, timer and shared prescaler
//
// How it works
// - twelve-bit configuration word sets device options
// - bit 7 low protects data memory
// - bit 6 picks 8 or 4 MHz
// - bit 5 makes shared pin reset input
// - bit 4 low protects program memory
// - bit 3 alone enables the watchdog
// - codes 0-2 are crystal modes, long hold
// - code 3 external clock, pin free, short hold
// - codes 4/5 internal rc, short hold
// - codes 6/7 external rc, short hold
// - crystal modes hold reset 18 ms always
// - rc modes hold 1 ms, power-up only
// - watchdog counts its own rc ticks
// - pin change or timeout ends sleep
// - assign bit routes prescaler timer or watchdog
// - clear instruction (prescaler on watchdog) or timer write (prescaler on timer) clears prescaler
//
// Design decisions made here: the placing of the registers and the AHB-Lite interface to the registers.
`include "cfg_defines.vh"
module config_word_osc_reset_select #(
  parameter [`DRT_W-1:0] LONG_CYC  = `DRT_LONG_MS * `CLK_KHZ,
  parameter [`DRT_W-1:0] SHORT_CYC = `DRT_SHORT_MS * `CLK_KHZ
) (
  // clock and reset
  input  wire               mclk_in,
  input  wire               arst_n_in,
  // ahb-lite slave
  input  wire               hsel_in,
  input  wire [31:0]        haddr_in,
  input  wire [1:0]         htrans_in,
  input  wire               hwrite_in,
  input  wire [2:0]         hsize_in,
  input  wire               hready_in,
  input  wire [31:0]        hwdata_in,
  output wire [31:0]        hrdata_out,
  output wire               hreadyout_out,
  output wire               hresp_out,
  // nonvolatile word and pins
  input  wire [`CFG_W-1:0]  cfg_word_in,
  input  wire               reset_pin_in,
  input  wire [5:0]         port_pins_in,
  input  wire               wdt_tick_in,
  // decoded options
  output wire               data_mem_protect_n_out,
  output wire               prog_mem_protect_n_out,
  output wire               int_osc_freq_sel_out,
  output wire               reset_pin_enable_out,
  output wire               watchdog_enable_out,
  output wire [`MODE_W-1:0] osc_mode_out,
  output wire               port_pin_four_gpio_out,
  // core status
  output wire               pin_three_gpio_out,
  output wire               clkout_out,
  output wire               core_reset_n_out,
  output wire               sleep_out
);
  // one-hot sequencer states
  localparam [4:0] ST_LOAD  = 5'b0_0001;
  localparam [4:0] ST_ARM   = 5'b0_0010;
  localparam [4:0] ST_HOLD  = 5'b0_0100;
  localparam [4:0] ST_RUN   = 5'b0_1000;
  localparam [4:0] ST_SLEEP = 5'b1_0000;

  reg  [4:0]        state_q;      // sequencer state
  reg  [4:0]        state_d;
  reg  [`CFG_W-1:0] cfg_q;        // captured configuration word
  reg               por_q;        // first hold after power-up pending
  reg               por_d;
  reg  [5:0]        pins_prev_q;  // last port pin levels
  reg               pin3_q;       // shared pin as general input
  reg  [1:0]        div_q;        // instruction cycle divider
  reg               clkout_q;     // clock-out pin level
  reg  [7:0]        opt_q;        // option register
  reg  [7:0]        tmr_q;        // timer count register
  reg  [7:0]        wdt_q;        // watchdog count
  reg  [7:0]        presc_q;      // shared prescaler
  reg               tout_q;       // sticky watchdog timeout
  // bus state
  reg               wr_q;         // write data phase pending
  reg               rd_q;         // read wait cycle pending
  reg  [7:0]        ofs_q;        // latched byte offset
  reg               ok_q;         // latched offset in range
  reg  [31:0]       rdata_q;      // read data
  reg  [31:0]       rmux;         // read data selection

  wire              dec_crystal;  // crystal mode selected
  wire              dec_clkout;   // clock-out on second pin
  wire              hold_busy;    // reset hold running
  wire              hold_done;    // last hold cycle
  reg               hold_load;    // start reset hold
  wire              core_rst;     // core held in reset
  wire              pin_reset;    // reset pin asserted
  wire              pin_chg;      // any port pin changed
  wire              running;      // run or sleep
  wire              instr_tick;   // one pulse per instruction cycle
  wire              prescaler_assign;          // prescaler to watchdog
  wire [2:0]        ratio;        // prescale ratio
  wire [7:0]        tmr_mask;     // timer terminal count
  wire [7:0]        pmask;        // active terminal count
  wire              wdt_ovf;      // watchdog count wraps
  wire              psrc;         // prescaler input tick
  wire              pout;         // prescaler output tick
  wire              wdt_tout;     // watchdog time-out event
  wire              acc;          // address phase taken
  wire              wr_opt;       // option write
  wire              wr_tmr;       // timer write
  wire              wr_cmd;       // command write
  wire              wclr;         // watchdog clear command
  wire              sleep_req;    // enter sleep command
  wire              pclr;         // prescaler clear

  // decoded fields of the captured word
  cfg_decode u_dec (
    .cfg_in        (cfg_q),
    .dprot_n_out   (data_mem_protect_n_out),
    .ifreq_out     (int_osc_freq_sel_out),
    .rpin_en_out   (reset_pin_enable_out),
    .pprot_n_out   (prog_mem_protect_n_out),
    .wdt_en_out    (watchdog_enable_out),
    .mode_out      (osc_mode_out),
    .crystal_out   (dec_crystal),
    .clkout_en_out (dec_clkout),
    .pin4_gpio_out (port_pin_four_gpio_out)
  );

  // reset hold timer
  hold_counter #(
    .WIDTH (`DRT_W)
  ) u_hold (
    .clk_in    (mclk_in),
    .arst_n_in (arst_n_in),
    .load_in   (hold_load),
    .count_in  (dec_crystal ? LONG_CYC : SHORT_CYC),
    .busy_out  (hold_busy),
    .done_out  (hold_done)
  );

  assign core_rst   = (state_q == ST_LOAD) | (state_q == ST_ARM) | (state_q == ST_HOLD);
  assign running    = (state_q == ST_RUN) | (state_q == ST_SLEEP);
  // pin is a reset only when enabled, else tied inactive
  assign pin_reset  = reset_pin_enable_out & ~reset_pin_in;
  assign pin_chg    = |(port_pins_in ^ pins_prev_q);
  assign instr_tick = (state_q == ST_RUN) & (div_q == `ICYC_LAST);

  // prescaler routing and terminal counts
  assign prescaler_assign      = opt_q[`OPT_PSA_BIT];
  assign ratio    = opt_q[`OPT_PS_HI:0];
  assign tmr_mask = 8'hff >> (3'h7 - ratio);
  assign pmask    = prescaler_assign ? (tmr_mask >> 1) : tmr_mask;
  // watchdog counts its own rc ticks, only the word enables it
  assign wdt_ovf  = watchdog_enable_out & running & wdt_tick_in & (wdt_q == 8'hff);
  assign psrc     = prescaler_assign ? wdt_ovf : instr_tick;
  assign pout     = psrc & (presc_q == pmask);
  assign wdt_tout = prescaler_assign ? pout : wdt_ovf;

  // bus decode
  assign acc       = hsel_in & htrans_in[1] & hready_in;
  assign wr_opt    = wr_q & ok_q & (ofs_q == `OFS_OPT);
  assign wr_tmr    = wr_q & ok_q & (ofs_q == `OFS_TMR);
  assign wr_cmd    = wr_q & ok_q & (ofs_q == `OFS_CMD);
  assign wclr      = wr_cmd & hwdata_in[`CMD_WCLR_BIT];
  assign sleep_req = wr_cmd & hwdata_in[`CMD_SLEEP_BIT];
  // clear goes with the current owner of the prescaler
  assign pclr      = (wclr & prescaler_assign) | (wr_tmr & ~prescaler_assign);

  assign hrdata_out         = rdata_q;
  assign hreadyout_out      = ~rd_q;
  assign hresp_out          = 1'b0;
  assign pin_three_gpio_out = pin3_q;
  assign clkout_out         = clkout_q;
  assign core_reset_n_out   = ~core_rst;
  assign sleep_out          = (state_q == ST_SLEEP);

  // sequencer: capture, hold, run, sleep
  always @* begin
    state_d   = state_q;
    por_d     = por_q;
    hold_load = 1'b0;
    case (state_q)
      ST_LOAD: begin
        state_d = ST_ARM;
      end
      ST_ARM: begin
        if (!pin_reset) begin
          if (dec_crystal | por_q) begin
            hold_load = 1'b1;
            state_d   = ST_HOLD;
          end else begin
            state_d = ST_RUN;
          end
        end
      end
      ST_HOLD: begin
        if (pin_reset) begin
          state_d = ST_ARM;
        end else if (hold_done) begin
          por_d   = 1'b0;
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (pin_reset | wdt_tout) begin
          state_d = ST_ARM;
        end else if (sleep_req) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (pin_reset | wdt_tout | pin_chg) begin
          state_d = ST_ARM;
        end
      end
      default: begin
        state_d = ST_LOAD;
      end
    endcase
  end

  // sequencer registers and word capture
  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= ST_LOAD;
      por_q   <= 1'b1;
      cfg_q   <= {`CFG_W{1'b0}};
    end else begin
      state_q <= state_d;
      por_q   <= por_d;
      // word taken once after power-up, fixed afterwards
      if (state_q == ST_LOAD) begin
        cfg_q <= cfg_word_in;
      end
    end
  end

  // pin sampling, divider and clock-out
  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pins_prev_q <= 6'h00;
      pin3_q      <= 1'b0;
      div_q       <= 2'h0;
      clkout_q    <= 1'b0;
    end else begin
      pins_prev_q <= port_pins_in;
      pin3_q      <= ~reset_pin_enable_out & reset_pin_in;
      div_q       <= div_q + 2'h1;
      // instruction clock out only in the clock-out rc codes
      clkout_q    <= dec_clkout & (state_q == ST_RUN) & div_q[1];
    end
  end

  // option, timer, watchdog and prescaler
  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      opt_q   <= `OPT_RESET;
      tmr_q   <= 8'h00;
      wdt_q   <= 8'h00;
      presc_q <= 8'h00;
    end else if (core_rst) begin
      // every reset restores option, clears watchdog and prescaler
      opt_q   <= `OPT_RESET;
      wdt_q   <= 8'h00;
      presc_q <= 8'h00;
    end else begin
      if (wr_opt) begin
        opt_q <= hwdata_in[7:0];
      end
      // write wins over a count in the same cycle
      if (wr_tmr) begin
        tmr_q <= hwdata_in[7:0];
      end else if (prescaler_assign ? instr_tick : pout) begin
        tmr_q <= tmr_q + 8'h01;
      end
      if (wclr) begin
        wdt_q <= 8'h00;
      end else if (watchdog_enable_out & wdt_tick_in) begin
        wdt_q <= wdt_q + 8'h01;
      end
      if (pclr) begin
        presc_q <= 8'h00;
      end else if (pout) begin
        presc_q <= 8'h00;
      end else if (psrc) begin
        presc_q <= presc_q + 8'h01;
      end
    end
  end

  // sticky time-out flag, a new time-out beats the clear
  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tout_q <= 1'b0;
    end else if (wdt_tout) begin
      tout_q <= 1'b1;
    end else if (wclr) begin
      tout_q <= 1'b0;
    end
  end

  // read data selection
  always @* begin
    rmux = 32'h0000_0000;
    if (ok_q) begin
      case (ofs_q)
        `OFS_CFG:  rmux[`CFG_W-1:0] = cfg_q;
        `OFS_OPT:  rmux[7:0]        = opt_q;
        `OFS_TMR:  rmux[7:0]        = tmr_q;
        `OFS_STAT: begin
          rmux[`ST_TOUT_BIT]           = tout_q;
          rmux[`ST_SLEEP_BIT]          = (state_q == ST_SLEEP);
          rmux[`ST_HOLD_BIT]           = hold_busy;
          rmux[`ST_WDT_HI:`ST_WDT_LO]  = wdt_q;
        end
        default:   rmux = 32'h0000_0000;
      endcase
    end
  end

  // ahb-lite address and data phases, reads take one wait cycle
  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_q    <= 1'b0;
      rd_q    <= 1'b0;
      ofs_q   <= 8'h00;
      ok_q    <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      wr_q <= acc & hwrite_in;
      rd_q <= acc & ~hwrite_in;
      if (acc) begin
        ofs_q <= haddr_in[7:0];
        ok_q  <= (haddr_in[31:8] == 24'h00_0000) & (haddr_in[1:0] == 2'h0);
      end
      if (rd_q) begin
        rdata_q <= rmux;
      end
    end
  end
endmodule // config_word_osc_reset_select

// [core/cfg_defines.vh]
// constants shared by the configuration word, reset hold and prescaler logic
`ifndef CFG_DEFINES_VH
`define CFG_DEFINES_VH
// configuration word layout
`define CFG_W          12
`define CFG_DPROT_BIT  7
`define CFG_IFREQ_BIT  6
`define CFG_RPIN_BIT   5
`define CFG_PPROT_BIT  4
`define CFG_WDTEN_BIT  3
`define CFG_OSC_HI     2
`define CFG_OSC_LO     0
// oscillator select codes
`define OSC_LP         3'h0
`define OSC_XT         3'h1
`define OSC_HS         3'h2
`define OSC_EC         3'h3
`define OSC_IRC_IO     3'h4
`define OSC_IRC_CLK    3'h5
`define OSC_ERC_IO     3'h6
`define OSC_ERC_CLK    3'h7
// bit positions in the one-hot mode output
`define MODE_W         6
`define MODE_LP        0
`define MODE_XT        1
`define MODE_HS        2
`define MODE_IRC       3
`define MODE_ERC       4
`define MODE_EC        5
// reset hold timing
`define CLK_KHZ        200000
`define DRT_LONG_MS    18
`define DRT_SHORT_MS   1
`define DRT_W          22
// register byte offsets
`define OFS_CFG        8'h00
`define OFS_OPT        8'h04
`define OFS_TMR        8'h08
`define OFS_CMD        8'h0c
`define OFS_STAT       8'h10
// option register
`define OPT_RESET      8'hff
`define OPT_PSA_BIT    3
`define OPT_PS_HI      2
// command register bits
`define CMD_WCLR_BIT   0
`define CMD_SLEEP_BIT  1
// status register bits
`define ST_TOUT_BIT    0
`define ST_SLEEP_BIT   1
`define ST_HOLD_BIT    2
`define ST_WDT_LO      8
`define ST_WDT_HI      15
// instruction cycle is four clocks
`define ICYC_LAST      2'h3
`endif

// [core/cfg_decode.v]
// decoder of the captured configuration word into fields and oscillator mode
`include "cfg_defines.vh"
module cfg_decode (
  // captured word
  input  wire [`CFG_W-1:0]  cfg_in,
  // decoded fields
  output wire               dprot_n_out,
  output wire               ifreq_out,
  output wire               rpin_en_out,
  output wire               pprot_n_out,
  output wire               wdt_en_out,
  // oscillator mode
  output reg  [`MODE_W-1:0] mode_out,
  output wire               crystal_out,
  output wire               clkout_en_out,
  output wire               pin4_gpio_out
);
  wire [2:0] osc_select;    // oscillator select field

  assign osc_select  = cfg_in[`CFG_OSC_HI:`CFG_OSC_LO];
  assign dprot_n_out = cfg_in[`CFG_DPROT_BIT];
  assign ifreq_out   = cfg_in[`CFG_IFREQ_BIT];
  assign rpin_en_out = cfg_in[`CFG_RPIN_BIT];
  assign pprot_n_out = cfg_in[`CFG_PPROT_BIT];
  assign wdt_en_out  = cfg_in[`CFG_WDTEN_BIT];
  // crystal modes own both oscillator pins
  assign crystal_out   = mode_out[`MODE_LP] | mode_out[`MODE_XT] | mode_out[`MODE_HS];
  // odd rc codes put the instruction clock on the second pin
  assign clkout_en_out = (osc_select == `OSC_IRC_CLK) | (osc_select == `OSC_ERC_CLK);
  assign pin4_gpio_out = (osc_select == `OSC_EC) | (osc_select == `OSC_IRC_IO)
                       | (osc_select == `OSC_ERC_IO);

  // one-hot mode from the select code
  always @* begin
    mode_out = {`MODE_W{1'b0}};
    case (osc_select)
      `OSC_LP:      mode_out[`MODE_LP]  = 1'b1;
      `OSC_XT:      mode_out[`MODE_XT]  = 1'b1;
      `OSC_HS:      mode_out[`MODE_HS]  = 1'b1;
      `OSC_EC:      mode_out[`MODE_EC]  = 1'b1;
      `OSC_IRC_IO,
      `OSC_IRC_CLK: mode_out[`MODE_IRC] = 1'b1;
      default:      mode_out[`MODE_ERC] = 1'b1;
    endcase
  end
endmodule // cfg_decode

// [core/hold_counter.v]
// loadable down counter that holds busy for a given number of cycles
module hold_counter #(
  parameter WIDTH = 22
) (
  // clock and reset
  input  wire             clk_in,
  input  wire             arst_n_in,
  // control
  input  wire             load_in,
  input  wire [WIDTH-1:0] count_in,
  // status
  output wire             busy_out,
  output wire             done_out
);
  reg [WIDTH-1:0] cnt_q;    // cycles left
  reg             busy_q;   // counting

  assign busy_out = busy_q;
  assign done_out = busy_q & (cnt_q == {{(WIDTH-1){1'b0}}, 1'b1});

  // count down from the loaded value, stop at one
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_q  <= {WIDTH{1'b0}};
      busy_q <= 1'b0;
    end else if (load_in) begin
      cnt_q  <= count_in;
      busy_q <= 1'b1;
    end else if (done_out) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      cnt_q  <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule // hold_counter

// [dv/cfg_osc_asserts.sv]
// concurrent checks on decoded options, reset hold, pin reset and wake-up
module cfg_osc_asserts #(
  parameter [21:0] LONG_CYC  = 22'h00_0028,
  parameter [21:0] SHORT_CYC = 22'h00_000a
) (
  // clock and reset
  input wire        mclk_in,
  input wire        arst_n_in,
  // stored word and pins
  input wire [11:0] cfg_word_in,
  input wire        reset_pin_in,
  input wire [5:0]  port_pins_in,
  // decoded options and core status
  input wire        data_mem_protect_n_out,
  input wire        prog_mem_protect_n_out,
  input wire        int_osc_freq_sel_out,
  input wire        reset_pin_enable_out,
  input wire        watchdog_enable_out,
  input wire [5:0]  osc_mode_out,
  input wire        port_pin_four_gpio_out,
  input wire        pin_three_gpio_out,
  input wire        clkout_out,
  input wire        core_reset_n_out,
  input wire        sleep_out
);
  reg         seen_q; // word already copied
  reg  [11:0] cap_q;  // our own copy of the word
  reg         up_q;   // first hold is over
  reg  [21:0] low_q;  // cycles spent in core reset
  wire [2:0]  osc  = cap_q[2:0];
  wire        xtal = osc < 3'h3;
  wire [21:0] hold = xtal ? LONG_CYC : SHORT_CYC;
  wire [5:0]  mode = (osc == 3'h3) ? 6'h20 : osc[2] ? (osc[1] ? 6'h10 : 6'h08) : 6'h01 << osc;
  // copy the word on the first edge after reset and count reset cycles
  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      seen_q <= 1'h0;
      cap_q  <= 12'h000;
      up_q   <= 1'h0;
      low_q  <= 22'h00_0000;
    end else begin
      seen_q <= 1'h1;
      if (!seen_q) begin
        cap_q <= cfg_word_in;
      end
      up_q  <= up_q | core_reset_n_out;
      low_q <= core_reset_n_out ? 22'h00_0000 : low_q + 22'h00_0001;
    end
  end
  default clocking dck @(posedge mclk_in);
  endclocking
  default disable iff (!arst_n_in);
  // shared pin low while it acts as reset
  sequence s_pin_held;
    (reset_pin_enable_out && !reset_pin_in) [*3];
  endsequence
  // later pin reset in an rc mode ends
  sequence s_rc_pin_up;
    up_q && !xtal && reset_pin_enable_out && !core_reset_n_out && $rose(reset_pin_in);
  endsequence
  a_flag_bits: assert property (seen_q |->
    {data_mem_protect_n_out, int_osc_freq_sel_out, reset_pin_enable_out,
     prog_mem_protect_n_out, watchdog_enable_out} == cap_q[7:3]) else $error("option bits");
  a_mode_decode: assert property (seen_q |-> osc_mode_out == mode)
    else $error("oscillator mode");
  a_pin_four: assert property (seen_q |->
    port_pin_four_gpio_out == (osc == 3'h3 || osc == 3'h4 || osc == 3'h6)) else $error("pin four");
  a_clkout_off: assert property (seen_q && !(osc[2] && osc[0]) |-> !clkout_out)
    else $error("clock out active");
  a_first_hold: assert property ($rose(core_reset_n_out) && !up_q |->
    low_q >= hold && low_q <= hold + 22'h00_0005) else $error("power-up hold length");
  a_long_hold: assert property ($rose(core_reset_n_out) && xtal |-> low_q >= LONG_CYC)
    else $error("crystal hold short");
  a_pin_reset: assert property (s_pin_held |=> !core_reset_n_out)
    else $error("pin reset missed");
  a_rc_release: assert property (s_rc_pin_up |-> ##[1:3] core_reset_n_out)
    else $error("rc reset held");
  a_pin_input: assert property (seen_q && $past(seen_q) && !reset_pin_enable_out |->
    pin_three_gpio_out == $past(reset_pin_in)) else $error("pin input value");
  a_wake_pin: assert property (sleep_out && $changed(port_pins_in) |-> ##[1:4] !sleep_out)
    else $error("no wake on pin");
endmodule // cfg_osc_asserts

bind config_word_osc_reset_select cfg_osc_asserts #(
  .LONG_CYC (LONG_CYC),
  .SHORT_CYC(SHORT_CYC)
) u_cfg_osc_asserts (.*);

// [dv/osc_source_model.sv]
// far side: reset pin with pull-up, port pins and the watchdog's own rc ticks
module osc_source_model (
  // system clock for the sync stage
  input  wire       mclk_in,
  // bench controls
  input  wire       tick_run_in,
  input  wire       pin_low_in,
  input  wire [5:0] pins_in,
  // lines into the device
  output wire       reset_pin_out,
  output wire [5:0] port_pins_out,
  output reg        wdt_tick_out
);
  timeunit 1ns;
  timeprecision 100ps;
  reg       rc_q   = 1'h0; // watchdog rc, unrelated to mclk
  reg [1:0] sync_q = 2'h0; // rc edge synchroniser
  initial wdt_tick_out = 1'h0;
  // own oscillator, standing still when stopped
  always #6.5 begin
    if (tick_run_in) begin
      rc_q = ~rc_q;
    end
  end
  // rc rising edge becomes one mclk pulse
  always @(posedge mclk_in) begin
    sync_q       <= {sync_q[0], rc_q};
    wdt_tick_out <= sync_q[0] & ~sync_q[1];
  end
  assign reset_pin_out = ~pin_low_in;
  assign port_pins_out = pins_in;
endmodule // osc_source_model

// [dv/tb_config_word_osc_reset_select.sv]
// testbench for configuration decode, reset hold, prescaler and sleep
`include "cfg_defines.vh"
module tb_config_word_osc_reset_select;
  timeunit 1ns;
  timeprecision 100ps;
  localparam [21:0] LONG  = 22'h00_0028; // shortened crystal hold
  localparam [21:0] SHORT = 22'h00_000a; // shortened rc hold
  logic        mclk_in   = 1'h0;
  logic        arst_n_in = 1'h0;
  logic        hsel      = 1'h0;
  logic [31:0] haddr     = 32'h0000_0000;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'h0;
  logic [31:0] hwdata    = 32'h0000_0000;
  logic [11:0] cfg_word  = 12'h000;
  logic        tick_run  = 1'h0;
  logic        pin_low   = 1'h0;
  logic [5:0]  pins      = 6'h00;
  wire  [31:0] hrdata;
  wire  [5:0]  port_pins, osc_mode;
  wire         hready, hresp, reset_pin, wdt_tick, dmp, pmp, ifs, rpe, wde;
  wire         pin4, pin3, clkout, core_n, sleep;
  int          bad_count = 0, cmp_count = 0, cyc = 0;
  config_word_osc_reset_select #(.LONG_CYC(LONG), .SHORT_CYC(SHORT))
    u_config_word_osc_reset_select (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
    .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hready_in(hready),
    .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .cfg_word_in(cfg_word), .reset_pin_in(reset_pin), .port_pins_in(port_pins),
    .wdt_tick_in(wdt_tick), .data_mem_protect_n_out(dmp), .prog_mem_protect_n_out(pmp),
    .int_osc_freq_sel_out(ifs), .reset_pin_enable_out(rpe), .watchdog_enable_out(wde),
    .osc_mode_out(osc_mode), .port_pin_four_gpio_out(pin4), .pin_three_gpio_out(pin3),
    .clkout_out(clkout), .core_reset_n_out(core_n), .sleep_out(sleep));
  osc_source_model u_osc_source_model (.mclk_in(mclk_in), .tick_run_in(tick_run),
    .pin_low_in(pin_low), .pins_in(pins), .reset_pin_out(reset_pin),
    .port_pins_out(port_pins), .wdt_tick_out(wdt_tick));
  initial begin
    forever #2.5 mclk_in = ~mclk_in;
  end
  task end_sim;
    if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // word compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t word %h expected %h", $time, got, exp);
    end
  endtask
  // flag compare
  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  // one bus transfer: address phase, then data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    haddr  <= {24'h00_0000, a};
    hwrite <= wr;
    do @(posedge mclk_in); while (hready !== 1'h1);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk_in); while (hready !== 1'h1);
    rd = hrdata;
    chkb(hresp, 1'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'h1, a, d, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    ahb(1'h0, a, 32'h0000_0000, d);
  endtask
  // cycles until the core leaves reset
  task automatic wait_up(output int n);
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (core_n !== 1'h1);
  endtask
  task automatic powerup(input logic [11:0] w, output int n);
    cfg_word  <= w;
    arst_n_in <= 1'h0;
    repeat (3) @(posedge mclk_in);
    arst_n_in <= 1'h1;
    wait_up(n);
  endtask
  // cycles until sleep ends, bounded
  task automatic wait_wake(output int n);
    n = 0;
    while (sleep === 1'h1 && n < 1000) begin
      @(posedge mclk_in);
      n++;
    end
  endtask
  // every oscillator code, option bits in both polarities
  task automatic t_modes;
    logic [11:0] w;
    logic [31:0] d;
    logic [5:0]  em [8] = '{6'h01, 6'h02, 6'h04, 6'h20, 6'h08, 6'h08, 6'h10, 6'h10};
    logic        c;
    int          n, h;
    for (logic [3:0] i = 0; i < 8; i++) begin
      w = {4'ha, i[2:0] ^ 3'h5, i[1:0] ^ 2'h2, i[2:0]};
      h = (i < 3) ? LONG : SHORT;
      powerup(w, n);
      chkb(n inside {[h:h + 5]}, 1'h1);
      chk({27'h0, dmp, ifs, rpe, pmp, wde}, {27'h0, w[7:3]});
      chk({26'h0, osc_mode}, {26'h0, em[i[2:0]]});
      chkb(pin4, i == 3 || i == 4 || i == 6);
      c = 1'h0;
      repeat (8) begin
        @(posedge mclk_in);
        c = c | clkout;
      end
      chkb(c, i == 5 || i == 7);
      rd(`OFS_CFG, d);
      chk(d, {20'h0_0000, w});
    end
    rd(8'h14, d);
    chk(d, 32'h0000_0000);
  endtask
  // a new stored word must not reach the running options
  task automatic t_freeze;
    logic [31:0] d;
    cfg_word <= 12'h000;
    repeat (4) @(posedge mclk_in);
    chk({26'h0, osc_mode}, 32'h0000_0010);
    rd(`OFS_CFG, d);
    chk(d, 32'h0000_0a4f);
  endtask
  // pin reset in rc and crystal modes, then pin as plain input
  task automatic t_pin;
    int n;
    powerup(12'h024, n);
    pin_low <= 1'h1;
    repeat (4) @(posedge mclk_in);
    chkb(core_n, 1'h0);
    pin_low <= 1'h0;
    wait_up(n);
    chkb(n <= 4, 1'h1);
    powerup(12'h021, n);
    pin_low <= 1'h1;
    repeat (4) @(posedge mclk_in);
    pin_low <= 1'h0;
    wait_up(n);
    chkb(n >= LONG, 1'h1);
    powerup(12'h004, n);
    pin_low <= 1'h1;
    repeat (4) @(posedge mclk_in);
    chk({30'h0, core_n, pin3}, 32'h0000_0002);
    pin_low <= 1'h0;
  endtask
  // timer rate per assignment, watchdog clear, overflow and disable
  task automatic t_dog;
    logic [31:0] d;
    int          n;
    powerup(12'h00c, n);
    wr(`OFS_OPT, 32'h0000_0000);
    wr(`OFS_TMR, 32'h0000_0000);
    repeat (80) @(posedge mclk_in);
    rd(`OFS_TMR, d);
    chkb(d inside {[8:12]}, 1'h1);
    wr(`OFS_CMD, 32'h0000_0001);
    wr(`OFS_TMR, 32'h0000_0000);
    wr(`OFS_OPT, 32'h0000_0000);
    wr(`OFS_CMD, 32'h0000_0001);
    wr(`OFS_OPT, 32'h0000_0008);
    wr(`OFS_TMR, 32'h0000_0000);
    repeat (80) @(posedge mclk_in);
    rd(`OFS_TMR, d);
    chkb(d inside {[18:23]}, 1'h1);
    tick_run <= 1'h1;
    repeat (40) @(posedge mclk_in);
    tick_run <= 1'h0;
    repeat (8) @(posedge mclk_in);
    rd(`OFS_STAT, d);
    chkb(d[15:8] != 8'h00, 1'h1);
    wr(`OFS_CMD, 32'h0000_0001);
    rd(`OFS_STAT, d);
    chk({24'h00_0000, d[15:8]}, 32'h0000_0000);
    tick_run <= 1'h1;
    n = 0;
    while (core_n === 1'h1 && n < 2000) begin
      @(posedge mclk_in);
      n++;
    end
    tick_run <= 1'h0;
    chkb(n inside {[600:720]}, 1'h1);
    wait_up(n);
    rd(`OFS_STAT, d);
    chkb(d[0], 1'h1);
    wr(`OFS_CMD, 32'h0000_0001);
    wr(`OFS_OPT, 32'h0000_0000);
    powerup(12'h004, n);
    tick_run <= 1'h1;
    n = 0;
    repeat (1000) begin
      @(posedge mclk_in);
      n += (core_n !== 1'h1);
    end
    tick_run <= 1'h0;
    chk(n, 32'h0000_0000);
  endtask
  // sleep left on a pin change, then on a watchdog overflow
  task automatic t_sleep;
    int n;
    wr(`OFS_CMD, 32'h0000_0002);
    repeat (2) @(posedge mclk_in);
    chkb(sleep, 1'h1);
    pins <= 6'h01;
    wait_wake(n);
    chkb(n <= 4, 1'h1);
    powerup(12'h00c, n);
    wr(`OFS_OPT, 32'h0000_0008);
    wr(`OFS_CMD, 32'h0000_0001);
    wr(`OFS_CMD, 32'h0000_0002);
    tick_run <= 1'h1;
    repeat (2) @(posedge mclk_in);
    wait_wake(n);
    tick_run <= 1'h0;
    chkb(n inside {[550:720]}, 1'h1);
  endtask
  // hang guard
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    t_modes();
    t_freeze();
    t_pin();
    t_dog();
    t_sleep();
    end_sim();
  end
endmodule // tb_config_word_osc_reset_select
